/* File: core/ibh_port.sv */
// Expansion bus host port: bus cycle sequencer with DMA acknowledge
`include "ibh_params.svh"

module ibh_port
   import ibh_pkg::*;
(
   input  wire logic        sys_clk,
   input  wire logic        sys_rst,
   // Processor command side
   input  wire logic        cmd_valid,
   output logic             cmd_ready,
   input  wire logic [1:0]  cmd_op,
   input  wire logic [19:0] cmd_addr,
   input  wire logic [7:0]  cmd_wdata,
   // DMA engine side
   input  wire logic [19:0] dma_addr,
   input  wire logic        dma_to_mem,
   input  wire logic        dma_last,
   input  wire logic [7:0]  dma_wdata,
   // Completion
   output logic             xfer_done,
   output logic             xfer_abort,
   output logic             xfer_dma,
   output logic [1:0]       xfer_chan,
   output logic [7:0]       rd_data,
   // Bus pins
   output logic [19:0]      sa,
   output logic             sa_oe_n,
   input  wire logic [7:0]  sd_in,
   output logic [7:0]       sd_out,
   output logic             sd_oe_n,
   output logic             aen,
   output logic             io_wr_n,
   output logic             io_rd_n,
   output logic             mem_rd_n,
   output logic             mem_wr_n,
   output logic             tc,
   output logic             ctl_oe_n,
   input  wire logic        ready,
   input  wire logic        bus_master_n,
   input  wire logic [3:0]  drq,
   output logic [3:0]       dma_ack_n
);

   localparam logic [3:0] SETUP_LAST  = 4'(`IBH_SETUP_CYC - 1);
   localparam logic [3:0] STROBE_LAST = 4'(`IBH_STROBE_CYC - 1);
   localparam logic [3:0] HOLD_LAST   = 4'(`IBH_HOLD_CYC - 1);

   typedef struct packed
   {
      ibh_state_t  st;
      logic [3:0]  cnt;
      ibh_op_t     op;
      logic        is_dma;
      logic        last;
      logic [1:0]  chan;
      logic [19:0] addr;
      logic [7:0]  wdata;
      logic [7:0]  rdata;
      logic        done;
      logic        abort;
   } ibh_port_state_t;

   ibh_port_state_t s;
   ibh_port_state_t next_s;

   ibh_arb_if arb_bus ();

   logic strobe_on;
   logic busy;
   logic is_write;

   // ----------------------------------------------------------------
   // Channel arbiter
   // ----------------------------------------------------------------
   ibh_dma_arb u_arb
   (
      .sys_clk (sys_clk),
      .sys_rst (sys_rst),
      .drq     (drq),
      .arb     (arb_bus.arb)
   );

   // ----------------------------------------------------------------
   // Cycle sequencer
   // ----------------------------------------------------------------
   // DMA wins over the processor so a held request is never starved
   assign cmd_ready = (s.st == IBH_IDLE) && bus_master_n && !arb_bus.req;

   always_comb
   begin
      next_s       = s;
      next_s.done  = 1'b0;
      next_s.abort = 1'b0;
      unique case (s.st)
         IBH_IDLE:
         begin
            if (bus_master_n && arb_bus.req)
            begin
               next_s.is_dma = 1'b1;
               next_s.chan   = arb_bus.chan;
               next_s.addr   = dma_addr;
               next_s.op     = dma_to_mem ? IBH_MEM_WR : IBH_MEM_RD;
               next_s.wdata  = dma_wdata;
               next_s.last   = dma_last;
               next_s.st     = IBH_SETUP;
               next_s.cnt    = SETUP_LAST;
            end
            else if (cmd_valid && cmd_ready)
            begin
               next_s.is_dma = 1'b0;
               next_s.addr   = cmd_addr;
               next_s.op     = ibh_op_t'(cmd_op);
               next_s.wdata  = cmd_wdata;
               next_s.last   = 1'b0;
               next_s.st     = IBH_SETUP;
               next_s.cnt    = SETUP_LAST;
            end
         end
         IBH_SETUP:
         begin
            if (s.cnt == 4'h0)
            begin
               next_s.st  = IBH_STROBE;
               next_s.cnt = STROBE_LAST;
            end
            else
            begin
               next_s.cnt = s.cnt - 4'h1;
            end
         end
         IBH_STROBE:
         begin
            if (s.cnt != 4'h0)
            begin
               next_s.cnt = s.cnt - 4'h1;
            end
            else if (ready)
            begin
               // Read data is taken on the last strobe cycle, before release
               if (!is_write)
               begin
                  next_s.rdata = sd_in;
               end
               next_s.st  = IBH_HOLD;
               next_s.cnt = HOLD_LAST;
            end
         end
         IBH_HOLD:
         begin
            if (s.cnt == 4'h0)
            begin
               next_s.st   = IBH_IDLE;
               next_s.done = 1'b1;
            end
            else
            begin
               next_s.cnt = s.cnt - 4'h1;
            end
         end
      endcase
      // Unfinished cycles are dropped; software must hand off to the master
      if (!bus_master_n && s.st != IBH_IDLE)
      begin
         next_s.st    = IBH_IDLE;
         next_s.abort = 1'b1;
      end
   end

   always_ff @(posedge sys_clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         s       <= '0;
         s.st    <= IBH_IDLE;
         s.addr  <= `IBH_RST_ADDR;
         s.wdata <= `IBH_RST_DATA;
         s.rdata <= `IBH_RST_DATA;
      end
      else
      begin
         s <= next_s;
      end
   end

   // Arbiter unlocks on the edge the sequencer goes idle, so no stale restart
   assign arb_bus.done = s.is_dma && (s.st != IBH_IDLE) && (next_s.st == IBH_IDLE);

   // ----------------------------------------------------------------
   // Pin decode
   // ----------------------------------------------------------------
   assign busy      = (s.st != IBH_IDLE);
   assign strobe_on = (s.st == IBH_STROBE);
   assign is_write  = (s.op == IBH_IO_WR) || (s.op == IBH_MEM_WR);

   assign sa       = s.addr;
   assign sd_out   = s.wdata;
   assign sd_oe_n  = !(bus_master_n && busy && is_write);
   assign aen      = s.is_dma && busy;
   assign io_wr_n  = !(strobe_on && s.op == IBH_IO_WR);
   assign io_rd_n  = !(strobe_on && s.op == IBH_IO_RD);
   assign mem_rd_n = !(strobe_on && s.op == IBH_MEM_RD);
   assign mem_wr_n = !(strobe_on && s.op == IBH_MEM_WR);
   assign tc       = s.is_dma && busy && s.last;
   // Acknowledges stay driven under an external master for handshaking
   assign sa_oe_n  = !bus_master_n;
   assign ctl_oe_n = !bus_master_n;

   genvar ch;
   generate
      for (ch = 0; ch < 4; ch++)
      begin : g_ack
         assign dma_ack_n[ch] = !(s.is_dma && busy && s.chan == 2'(ch));
      end
   endgenerate

   assign xfer_done  = s.done;
   assign xfer_abort = s.abort;
   assign xfer_dma   = s.is_dma;
   assign xfer_chan  = s.chan;
   assign rd_data    = s.rdata;

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (sys_rst);

   chk_ack_onehot: assert property ($onehot0(~dma_ack_n))
      else $error("More than one DMA acknowledge active");

   chk_tc_dma: assert property (tc |-> dma_ack_n != 4'hf && aen)
      else $error("Terminal count outside a DMA cycle");

   chk_aen_dma: assert property ((dma_ack_n != 4'hf) |-> aen)
      else $error("Address enable low during DMA cycle");

   chk_aen_cpu: assert property
      ((!io_wr_n || !io_rd_n || (busy && dma_ack_n == 4'hf)) |-> !aen)
      else $error("Address enable high during processor cycle");

   chk_one_strobe: assert property
      ($onehot0(~{io_wr_n, io_rd_n, mem_rd_n, mem_wr_n}))
      else $error("Two command strobes active together");

   chk_addr_stable: assert property
      (strobe_on && $past(strobe_on) |-> $stable(sa) && $stable(aen))
      else $error("Address moved while strobe active");

   // An external master may cut the strobe short, so its arrival cancels the check
   chk_strobe_len: assert property
      (@(posedge sys_clk) disable iff (sys_rst || !bus_master_n)
       $rose(strobe_on) |-> strobe_on[*5])
      else $error("Strobe shorter than five cycles");

   chk_ready_hold: assert property
      (strobe_on && !ready && bus_master_n |=> strobe_on)
      else $error("Strobe ended while ready low");

   chk_master_abort: assert property (!bus_master_n && busy |=> !busy && xfer_abort)
      else $error("Cycle not dropped under external master");

   chk_dma_steady: assert property
      (strobe_on && $past(strobe_on) |-> $stable(dma_ack_n) && $stable(tc))
      else $error("Acknowledge or terminal count moved during strobe");

   chk_idle_quiet: assert property
      (!busy |-> {io_wr_n, io_rd_n, mem_rd_n, mem_wr_n} == 4'hf && dma_ack_n == 4'hf && !tc)
      else $error("Strobe, acknowledge or terminal count active while idle");

   chk_master_off: assert property
      (!bus_master_n |-> sa_oe_n && ctl_oe_n && sd_oe_n)
      else $error("Bus still driven under external master");

   chk_write_data: assert property
      (!io_wr_n || !mem_wr_n |-> !sd_oe_n || !bus_master_n)
      else $error("Write strobe without data driven");

   chk_read_float: assert property (!io_rd_n || !mem_rd_n |-> sd_oe_n)
      else $error("Data driven during read strobe");

endmodule

/* File: core/ibh_params.svh */
// Timing and reset constants for the expansion bus host port
`ifndef IBH_PARAMS_SVH
`define IBH_PARAMS_SVH

// ----------------------------------------------------------------
// Clock
// ----------------------------------------------------------------
`define IBH_CLK_MHZ        20

// ----------------------------------------------------------------
// Cycle phase times in ns, and derived least counts (round up)
// ----------------------------------------------------------------
`define IBH_SETUP_NS       50
`define IBH_STROBE_NS      250
`define IBH_HOLD_NS        50
`define IBH_SETUP_CYC      ((`IBH_SETUP_NS * `IBH_CLK_MHZ + 999) / 1000)
`define IBH_STROBE_CYC     ((`IBH_STROBE_NS * `IBH_CLK_MHZ + 999) / 1000)
`define IBH_HOLD_CYC       ((`IBH_HOLD_NS * `IBH_CLK_MHZ + 999) / 1000)

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define IBH_RST_ADDR       20'h00000
`define IBH_RST_DATA       8'h00

`endif

/* File: core/ibh_pkg.sv */
// Types shared by the expansion bus host port modules
package ibh_pkg;

   // ----------------------------------------------------------------
   // Bus cycle phases, Gray coded along idle-setup-strobe-hold
   // ----------------------------------------------------------------
   typedef enum logic [1:0]
   {
      IBH_IDLE   = 2'h0,
      IBH_SETUP  = 2'h1,
      IBH_STROBE = 2'h3,
      IBH_HOLD   = 2'h2
   } ibh_state_t;

   // ----------------------------------------------------------------
   // Command kinds
   // ----------------------------------------------------------------
   typedef enum logic [1:0]
   {
      IBH_IO_RD  = 2'h0,
      IBH_IO_WR  = 2'h1,
      IBH_MEM_RD = 2'h2,
      IBH_MEM_WR = 2'h3
   } ibh_op_t;

endpackage

/* File: core/ibh_arb_if.sv */
// Channel request path between the DMA arbiter and the bus sequencer
interface ibh_arb_if;
   logic       req;
   logic [1:0] chan;
   logic       done;

   modport arb
   (
      output req,
      output chan,
      input  done
   );

   modport port
   (
      input  req,
      input  chan,
      output done
   );
endinterface

/* File: core/ibh_dma_arb.sv */
// Four-channel DMA request arbiter, locks one channel per cycle
module ibh_dma_arb
   import ibh_pkg::*;
(
   input  wire logic       sys_clk,
   input  wire logic       sys_rst,
   input  wire logic [3:0] drq,
   ibh_arb_if.arb          arb
);

   typedef struct packed
   {
      logic       locked;
      logic [1:0] chan;
   } ibh_arb_state_t;

   ibh_arb_state_t s;
   ibh_arb_state_t next_s;

   // ----------------------------------------------------------------
   // Channel pick, lowest index wins
   // ----------------------------------------------------------------
   always_comb
   begin
      next_s = s;
      if (s.locked && arb.done)
      begin
         next_s.locked = 1'b0;
      end
      else if (!s.locked && (|drq))
      begin
         // Requester holds its line until acknowledged, so a pick stays valid
         next_s.locked = 1'b1;
         for (int i = 3; i >= 0; i--)
         begin
            if (drq[i])
            begin
               next_s.chan = 2'(i);
            end
         end
      end
   end

   always_ff @(posedge sys_clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         s <= '0;
      end
      else
      begin
         s <= next_s;
      end
   end

   assign arb.req  = s.locked;
   assign arb.chan = s.chan;

   chk_chan_locked: assert property (@(posedge sys_clk) disable iff (sys_rst)
      s.locked && !arb.done |=> s.locked && $stable(s.chan))
      else $error("Granted channel changed before its cycle ended");

endmodule

/* File: verif/ibh_isa_slave.sv */
// Behavioural ISA memory and I/O slave with wait-state stretching
`include "ibh_params.svh"

module ibh_isa_slave
(
   input  wire logic        sys_clk,
   input  wire logic [19:0] sa,
   input  wire logic        aen,
   input  wire logic        io_wr_n,
   input  wire logic        io_rd_n,
   input  wire logic        mem_rd_n,
   input  wire logic        mem_wr_n,
   input  wire logic [7:0]  sd_out,
   input  wire logic        sd_oe_n,
   input  wire logic [3:0]  stretch,
   output logic [7:0]       sd_bus,
   output logic             ready = 1'b1
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [7:0] mem [256];
   logic [7:0] io  [256];
   logic [7:0] last_v = 8'h00;
   logic       armed  = 1'b0;
   logic [3:0] waits  = 4'h0;
   logic       io_sel;

   // I/O decode only while address enable is low
   assign io_sel = !aen;

   // Nobody keeps the data bus, so a released bus shows the inverse of its last value
   always_comb
   begin
      if (!sd_oe_n)
         sd_bus = sd_out;
      else if (!mem_rd_n)
         sd_bus = mem[sa[7:0]];
      else if (!io_rd_n && io_sel)
         sd_bus = io[sa[7:0]];
      else
         sd_bus = ~last_v;
   end

   always @(posedge sys_clk)
   begin
      last_v <= sd_bus;
      if (!mem_wr_n)
         mem[sa[7:0]] <= sd_bus;
      if (!io_wr_n && io_sel)
         io[sa[7:0]] <= sd_bus;
      // Ready held low so the cycle runs exactly stretch cycles past its default, for stretch up to 12
      if ({io_wr_n, io_rd_n, mem_rd_n, mem_wr_n} == 4'hf)
         armed <= 1'b1;
      else if (armed)
      begin
         armed <= 1'b0;
         ready <= (stretch == 4'h0);
         // Pulled low from the first strobe edge, so the host still sees it at strobe end
         waits <= stretch + 4'(`IBH_STROBE_CYC - 2);
      end
      else if (waits > 4'h1)
         waits <= waits - 4'h1;
      else
         ready <= 1'b1;
   end
endmodule

/* File: verif/test_isa_bus_host_port.sv */
// Self-checking bench for the expansion bus host port
module test_isa_bus_host_port
   import ibh_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   logic        sys_clk, sys_rst, cmd_valid, dma_to_mem, dma_last, ready, bus_master_n;
   logic        cmd_ready, xfer_done, xfer_abort, xfer_dma, sa_oe_n, sd_oe_n, aen, tc;
   logic        io_wr_n, io_rd_n, mem_rd_n, mem_wr_n, ctl_oe_n;
   logic [1:0]  cmd_op, xfer_chan;
   logic [19:0] cmd_addr, dma_addr, sa, a;
   logic [7:0]  cmd_wdata, dma_wdata, sd_in, sd_out, rd_data, d;
   logic [3:0]  drq, dma_ack_n, stretch;
   logic [7:0]  mem_ref [256];
   logic [7:0]  io_ref  [256];
   int          err_total, samples_checked;
   localparam logic [3:0] strb_of [4] = '{4'hb, 4'h7, 4'hd, 4'he};

   ibh_port dut
   (
      .sys_clk (sys_clk), .sys_rst (sys_rst), .cmd_valid (cmd_valid), .cmd_ready (cmd_ready),
      .cmd_op (cmd_op), .cmd_addr (cmd_addr), .cmd_wdata (cmd_wdata), .dma_addr (dma_addr),
      .dma_to_mem (dma_to_mem), .dma_last (dma_last), .dma_wdata (dma_wdata),
      .xfer_done (xfer_done), .xfer_abort (xfer_abort), .xfer_dma (xfer_dma),
      .xfer_chan (xfer_chan), .rd_data (rd_data), .sa (sa), .sa_oe_n (sa_oe_n),
      .sd_in (sd_in), .sd_out (sd_out), .sd_oe_n (sd_oe_n), .aen (aen), .io_wr_n (io_wr_n),
      .io_rd_n (io_rd_n), .mem_rd_n (mem_rd_n), .mem_wr_n (mem_wr_n), .tc (tc),
      .ctl_oe_n (ctl_oe_n), .ready (ready), .bus_master_n (bus_master_n), .drq (drq),
      .dma_ack_n (dma_ack_n)
   );
   ibh_isa_slave slave
   (
      .sys_clk (sys_clk), .sa (sa), .aen (aen), .io_wr_n (io_wr_n), .io_rd_n (io_rd_n),
      .mem_rd_n (mem_rd_n), .mem_wr_n (mem_wr_n), .sd_out (sd_out), .sd_oe_n (sd_oe_n),
      .stretch (stretch), .sd_bus (sd_in), .ready (ready)
   );

   // ----------------------------------------------------------------
   // Shared checking and bus tasks
   // ----------------------------------------------------------------
   task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
      samples_checked++;
      if (seen !== exp)
      begin
         err_total++;
         $display("mismatch at %0t: %s seen %h expected %h", $time, what, seen, exp);
      end
   endtask

   task automatic tally_and_finish();
      $display("Compared %0d values, %0d mismatches", samples_checked, err_total);
      if (err_total == 0 && samples_checked > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask

   // Follows one bus cycle to its done pulse, checking every strobe cycle
   task automatic watch(input int lat, input logic [3:0] strb, input logic a_en,
                        input logic [19:0] addr, input logic [3:0] ack);
      int n;
      n = 0;
      do
      begin
         @(negedge sys_clk);
         n++;
         if ({io_wr_n, io_rd_n, mem_rd_n, mem_wr_n} != 4'hf)
         begin
            check({io_wr_n, io_rd_n, mem_rd_n, mem_wr_n}, strb, "strobe");
            check({aen, sa}, {a_en, addr}, "aen and address");
            check(dma_ack_n, ack, "ack during strobe");
         end
      end
      while (xfer_done !== 1'b1 && n < 60);
      check(n, lat, "cycle length");
   endtask

   task automatic issue(input ibh_op_t op, input logic [19:0] addr, input logic [7:0] dat);
      @(posedge sys_clk);
      cmd_valid <= 1'b1;
      cmd_op <= op;
      cmd_addr <= addr;
      cmd_wdata <= dat;
      @(negedge sys_clk);
      while (cmd_ready !== 1'b1)
         @(negedge sys_clk);
      @(posedge sys_clk);
      cmd_valid <= 1'b0;
   endtask

   task automatic do_cmd(input ibh_op_t op, input logic [19:0] addr, input logic [7:0] dat);
      issue(op, addr, dat);
      watch(8 + stretch, strb_of[op], 1'b0, addr, 4'hf);
      check(xfer_dma, 1'b0, "processor cycle kind");
      case (op)
         IBH_IO_WR: io_ref[addr[7:0]] = dat;
         IBH_MEM_WR: mem_ref[addr[7:0]] = dat;
         IBH_IO_RD: check(rd_data, io_ref[addr[7:0]], "io read");
         default: check(rd_data, mem_ref[addr[7:0]], "mem read");
      endcase
   endtask

   task automatic dma_wait(input int ch, input logic [19:0] addr, input logic to_mem,
                           input logic last);
      int n;
      n = 0;
      while (dma_ack_n === 4'hf && n < 20)
      begin
         @(negedge sys_clk);
         n++;
      end
      check(dma_ack_n, 4'hf ^ (4'h1 << ch), "grant");
      check({aen, tc}, {1'b1, last}, "aen and tc at setup");
      @(posedge sys_clk);
      drq[ch] <= 1'b0;
      watch(7 + stretch, to_mem ? 4'he : 4'hd, 1'b1, addr, 4'hf ^ (4'h1 << ch));
      check({xfer_dma, xfer_chan}, {1'b1, ch[1:0]}, "dma channel");
      check({aen, tc, dma_ack_n}, 6'h0f, "dma end");
      if (to_mem)
         mem_ref[addr[7:0]] = dma_wdata;
      else
         check(rd_data, mem_ref[addr[7:0]], "dma read");
   endtask

   // ----------------------------------------------------------------
   // Clock, watchdog and main sequence
   // ----------------------------------------------------------------
   initial
   begin
      sys_clk = 1'b0;
      forever #25 sys_clk = ~sys_clk;
   end

   // About 230 clock cycles are expected; far beyond that means a hang
   initial
   begin
      #1ms;
      err_total++;
      tally_and_finish();
   end

   initial
   begin
      {sys_rst, bus_master_n} = 2'b11;
      {cmd_valid, cmd_op, cmd_addr, cmd_wdata} = '0;
      {dma_addr, dma_to_mem, dma_last, dma_wdata, drq, stretch} = '0;
      void'($urandom(32'h566e208b));
      repeat (6) @(posedge sys_clk);
      sys_rst <= 1'b0;
      @(negedge sys_clk);
      check({io_wr_n, io_rd_n, mem_rd_n, mem_wr_n, aen, tc, dma_ack_n, sd_oe_n}, 11'h79f,
            "reset pins");
      check(sa, 20'h00000, "reset address");
      $display("test reset done");
      // Every command kind back to back, with 0 to 3 wait states
      for (int i = 0; i < 4; i++)
      begin
         stretch = i[3:0];
         a = 20'($urandom);
         d = 8'($urandom);
         do_cmd(IBH_IO_WR, a, d);
         do_cmd(IBH_IO_RD, a, 8'h00);
         do_cmd(IBH_MEM_WR, a, ~d);
         do_cmd(IBH_MEM_RD, a, 8'h00);
      end
      $display("test commands done");
      // Two requests at once: channel 1 wins, channel 3 follows
      stretch = 4'h0;
      do_cmd(IBH_MEM_WR, a, 8'($urandom));
      @(posedge sys_clk);
      dma_addr <= a;
      drq <= 4'b1010;
      dma_wait(1, a, 1'b0, 1'b0);
      dma_wait(3, a, 1'b0, 1'b0);
      // Final stretched DMA write, read back by the processor
      stretch = 4'h2;
      @(posedge sys_clk);
      {dma_to_mem, dma_last, dma_wdata} <= {2'b11, 8'(~a[7:0])};
      drq[2] <= 1'b1;
      dma_wait(2, a, 1'b1, 1'b1);
      do_cmd(IBH_MEM_RD, a, 8'h00);
      $display("test dma done");
      // External master takes the bus in mid cycle
      stretch = 4'h0;
      issue(IBH_MEM_WR, a ^ 20'h00080, 8'h5a);
      repeat (2) @(posedge sys_clk);
      bus_master_n <= 1'b0;
      @(negedge sys_clk);
      check({sa_oe_n, ctl_oe_n, sd_oe_n, cmd_ready}, 4'he, "release");
      @(negedge sys_clk);
      check({xfer_abort, xfer_done}, 2'b10, "abort");
      @(posedge sys_clk);
      bus_master_n <= 1'b1;
      $display("test master done");
      tally_and_finish();
   end
endmodule
